// file: adccfg_cfg.svh
// Register offsets, field positions, writable masks and reset values of the ADC channel configuration block
`ifndef ADCCFG_CFG_SVH
`define ADCCFG_CFG_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ADCCFG_OFS_CTRL 8'h00
`define ADCCFG_OFS_MUX 8'h01
`define ADCCFG_OFS_IRQCTL 8'h02
`define ADCCFG_OFS_FLAGS 8'h03
`define ADCCFG_OFS_CMPL 8'h04
`define ADCCFG_OFS_CMPH 8'h05
`define ADCCFG_OFS_RESL 8'h06
`define ADCCFG_OFS_RESH 8'h07
`define ADCCFG_OFS_EVSTAT 8'h08
`define ADCCFG_OFS_EVMASK 8'h09
// ----------------------------------------
// Field positions
// ----------------------------------------
`define ADCCFG_CTRL_START 7
`define ADCCFG_CTRL_GAIN_HI 4
`define ADCCFG_CTRL_GAIN_LO 2
`define ADCCFG_CTRL_MODE_HI 1
`define ADCCFG_CTRL_MODE_LO 0
`define ADCCFG_MUX_POS_HI 6
`define ADCCFG_MUX_POS_LO 3
`define ADCCFG_MUX_NEG_HI 2
`define ADCCFG_MUX_NEG_LO 0
`define ADCCFG_IRQ_COND_HI 3
`define ADCCFG_IRQ_COND_LO 2
`define ADCCFG_IRQ_LVL_HI 1
`define ADCCFG_IRQ_LVL_LO 0
`define ADCCFG_FLAG_BIT 0
// ----------------------------------------
// Writable masks and reset values
// ----------------------------------------
`define ADCCFG_CTRL_WMASK 8'h9f
`define ADCCFG_MUX_WMASK 8'h7f
`define ADCCFG_IRQCTL_WMASK 8'h0f
`define ADCCFG_EV_WMASK 8'h03
`define ADCCFG_RST_BYTE 8'h00
`endif

// file: adccfg_channel.sv
// ADC channel configuration, selection decode and interrupt flag logic
`timescale 1ns/10ps
`include "adccfg_cfg.svh"
// How it works
// - Gain code 000 to 110 gives 1x to 64x in powers of two and code 111 gives one half.
// - Gain is applied only in differential mode with gain; otherwise the gain stage is bypassed.
// - In unsigned mode input kind 00 picks an internal source, 01 a pin, and 10 and 11 are reserved.
// - In signed mode 00 and 01 act as unsigned, 10 is differential and 11 differential with gain.
// - Positive select sits in bits 6:3 and in internal mode picks temperature, bandgap or supply tenth.
// - In pin modes positive select n routes analog pin n to the positive input.
// - Negative select in bits 2:0 steers the negative input only in differential modes.
// - Differential without gain: 000-011 pins 0-3, 101 pad ground, 111 internal ground, others reserved.
// - Differential with gain: 000-011 pins 4-7, 100 internal ground, 111 pad ground, others reserved.
// - Condition field bits 3:2 fires the flag on complete 00, below 01, above 11, with 10 reserved.
// - Priority field bits 1:0 enables the channel request and sets its level while the flag is set.
// - The flag sets on completion or on a met compare and clears on vector execution or a written one.
// - Start bit 7 begins a conversion and is cleared by hardware once the conversion starts.
module adccfg_channel
  import adccfg_pkg::*;
#(
  parameter int RES_W = 12
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Signed conversion setting from the converter controls
  input wire logic signed_conversion_select,
  // Conversion engine
  output logic conv_start,
  input wire logic conv_started,
  input wire logic conv_done,
  input wire logic [RES_W-1:0] conv_result,
  // Analog selections
  output logic [2:0] gain_select,
  output logic gain_enable,
  output adccfg_pos_kind_t pos_kind,
  output logic [3:0] pos_pin,
  output adccfg_neg_kind_t neg_kind,
  output logic [2:0] neg_pin,
  output logic input_reserved,
  // Interrupt controller
  output logic irq_request,
  output logic [1:0] irq_priority_level,
  input wire logic irq_vector_ack,
  // Event status interrupt
  output logic irq
);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic start_reg;
  logic [2:0] gain_reg;
  adccfg_input_kind_t channel_input_kind;
  logic [3:0] positive_input_select;
  logic [2:0] negative_input_select;
  adccfg_irq_cond_t irq_condition_select;
  logic [1:0] level_reg;
  logic flag_reg;
  logic [15:0] cmp_reg;
  logic [RES_W-1:0] res_reg;
  logic [1:0] evstat_reg;
  logic [1:0] evmask_reg;
  logic [7:0] rdata_next;
  logic cmp_met;
  logic flag_set;
  logic diff_with_amplification;
  logic diff_plain;
  logic [15:0] res_ext;
  logic [7:0] rd_addr_q;

  wire wr_ctrl = reg_wr && reg_addr == `ADCCFG_OFS_CTRL;
  wire wr_mux = reg_wr && reg_addr == `ADCCFG_OFS_MUX;
  wire wr_irqctl = reg_wr && reg_addr == `ADCCFG_OFS_IRQCTL;
  wire wr_flags = reg_wr && reg_addr == `ADCCFG_OFS_FLAGS;
  wire rd_evstat = reg_rd && reg_addr == `ADCCFG_OFS_EVSTAT;

  always_ff @(posedge clk) begin
    if (srst) begin
      start_reg <= 1'b0;
    end else if (wr_ctrl && reg_wdata[`ADCCFG_CTRL_START]) begin
      start_reg <= 1'b1;
    end else if (conv_started) begin
      start_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      gain_reg <= 3'h0;
      channel_input_kind <= ADCCFG_IN_INTERNAL;
    end else if (wr_ctrl) begin
      gain_reg <= reg_wdata[`ADCCFG_CTRL_GAIN_HI:`ADCCFG_CTRL_GAIN_LO];
      channel_input_kind <= adccfg_input_kind_t'(reg_wdata[`ADCCFG_CTRL_MODE_HI:`ADCCFG_CTRL_MODE_LO]);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      positive_input_select <= 4'h0;
      negative_input_select <= 3'h0;
    end else if (wr_mux) begin
      positive_input_select <= reg_wdata[`ADCCFG_MUX_POS_HI:`ADCCFG_MUX_POS_LO];
      negative_input_select <= reg_wdata[`ADCCFG_MUX_NEG_HI:`ADCCFG_MUX_NEG_LO];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      irq_condition_select <= ADCCFG_IRQ_COMPLETE;
      level_reg <= 2'h0;
    end else if (wr_irqctl) begin
      irq_condition_select <= adccfg_irq_cond_t'(reg_wdata[`ADCCFG_IRQ_COND_HI:`ADCCFG_IRQ_COND_LO]);
      level_reg <= reg_wdata[`ADCCFG_IRQ_LVL_HI:`ADCCFG_IRQ_LVL_LO];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cmp_reg <= 16'h0000;
    end else if (reg_wr && reg_addr == `ADCCFG_OFS_CMPL) begin
      cmp_reg[7:0] <= reg_wdata;
    end else if (reg_wr && reg_addr == `ADCCFG_OFS_CMPH) begin
      cmp_reg[15:8] <= reg_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      res_reg <= '0;
    end else if (conv_done) begin
      res_reg <= conv_result;
    end
  end

  // ----------------------------------------
  // Input mode and selection decode
  // ----------------------------------------
  assign diff_plain = signed_conversion_select && channel_input_kind == ADCCFG_IN_DIFF;
  assign diff_with_amplification = signed_conversion_select && channel_input_kind == ADCCFG_IN_DIFF_GAIN;

  always_comb begin
    pos_kind = ADCCFG_POS_NONE;
    pos_pin = 4'h0;
    input_reserved = 1'b0;
    if (channel_input_kind == ADCCFG_IN_INTERNAL) begin
      if (positive_input_select == 4'h0) begin
        pos_kind = ADCCFG_POS_TEMP;
      end else if (positive_input_select == 4'h1) begin
        pos_kind = ADCCFG_POS_BANDGAP;
      end else if (positive_input_select == 4'h2) begin
        pos_kind = ADCCFG_POS_SUPPLY_TENTH;
      end else begin
        input_reserved = 1'b1;
      end
    end else if (channel_input_kind == ADCCFG_IN_SINGLE || diff_plain || diff_with_amplification) begin
      pos_kind = ADCCFG_POS_PIN;
      pos_pin = positive_input_select;
    end else begin
      input_reserved = 1'b1;
    end
  end

  always_comb begin
    neg_kind = ADCCFG_NEG_NONE;
    neg_pin = 3'h0;
    if (diff_plain) begin
      if (!negative_input_select[2]) begin
        neg_kind = ADCCFG_NEG_PIN;
        neg_pin = {1'b0, negative_input_select[1:0]};
      end else if (negative_input_select == 3'h5) begin
        neg_kind = ADCCFG_NEG_PAD_GND;
      end else if (negative_input_select == 3'h7) begin
        neg_kind = ADCCFG_NEG_INT_GND;
      end
    end else if (diff_with_amplification) begin
      if (!negative_input_select[2]) begin
        neg_kind = ADCCFG_NEG_PIN;
        neg_pin = {1'b1, negative_input_select[1:0]};
      end else if (negative_input_select == 3'h4) begin
        neg_kind = ADCCFG_NEG_INT_GND;
      end else if (negative_input_select == 3'h7) begin
        neg_kind = ADCCFG_NEG_PAD_GND;
      end
    end
  end

  // Gain code passes through; 111 means one half in the gain stage
  assign gain_select = gain_reg;
  assign gain_enable = diff_with_amplification;
  assign conv_start = start_reg;

  // ----------------------------------------
  // Compare and channel flag
  // ----------------------------------------
  assign res_ext = signed_conversion_select ? 16'(signed'(res_reg)) : 16'(res_reg);

  always_comb begin
    cmp_met = 1'b0;
    if (irq_condition_select == ADCCFG_IRQ_BELOW) begin
      cmp_met = signed_conversion_select ? ($signed(res_ext) < $signed(cmp_reg)) : (res_ext < cmp_reg);
    end else if (irq_condition_select == ADCCFG_IRQ_ABOVE) begin
      cmp_met = signed_conversion_select ? ($signed(res_ext) > $signed(cmp_reg)) : (res_ext > cmp_reg);
    end
  end

  // Compare runs one cycle after the result is captured
  logic done_q;
  always_ff @(posedge clk) begin
    if (srst) begin
      done_q <= 1'b0;
    end else begin
      done_q <= conv_done;
    end
  end

  assign flag_set = done_q && (irq_condition_select == ADCCFG_IRQ_COMPLETE || cmp_met);

  always_ff @(posedge clk) begin
    if (srst) begin
      flag_reg <= 1'b0;
    end else if (flag_set) begin
      flag_reg <= 1'b1;
    end else if (irq_vector_ack || (wr_flags && reg_wdata[`ADCCFG_FLAG_BIT])) begin
      flag_reg <= 1'b0;
    end
  end

  assign irq_request = flag_reg && level_reg != 2'h0;
  assign irq_priority_level = level_reg;

  // ----------------------------------------
  // Event status: bit0 flag set, bit1 start taken
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      evstat_reg <= 2'h0;
    end else begin
      evstat_reg <= (rd_evstat ? 2'h0 : evstat_reg) | {start_reg && conv_started, flag_set};
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      evmask_reg <= 2'h0;
    end else if (reg_wr && reg_addr == `ADCCFG_OFS_EVMASK) begin
      evmask_reg <= reg_wdata[1:0];
    end
  end

  assign irq = |(evstat_reg & evmask_reg);

  // ----------------------------------------
  // Read path, reserved bits read as zero
  // ----------------------------------------
  assign rd_addr_q = reg_addr;
  always_comb begin
    rdata_next = 8'h00;
    if (rd_addr_q == `ADCCFG_OFS_CTRL) begin
      rdata_next = {start_reg, 2'b00, gain_reg, channel_input_kind};
    end else if (rd_addr_q == `ADCCFG_OFS_MUX) begin
      rdata_next = {1'b0, positive_input_select, negative_input_select};
    end else if (rd_addr_q == `ADCCFG_OFS_IRQCTL) begin
      rdata_next = {4'h0, irq_condition_select, level_reg};
    end else if (rd_addr_q == `ADCCFG_OFS_FLAGS) begin
      rdata_next = {7'h00, flag_reg};
    end else if (rd_addr_q == `ADCCFG_OFS_CMPL) begin
      rdata_next = cmp_reg[7:0];
    end else if (rd_addr_q == `ADCCFG_OFS_CMPH) begin
      rdata_next = cmp_reg[15:8];
    end else if (rd_addr_q == `ADCCFG_OFS_RESL) begin
      rdata_next = res_ext[7:0];
    end else if (rd_addr_q == `ADCCFG_OFS_RESH) begin
      rdata_next = res_ext[15:8];
    end else if (rd_addr_q == `ADCCFG_OFS_EVSTAT) begin
      rdata_next = {6'h00, evstat_reg};
    end else if (rd_addr_q == `ADCCFG_OFS_EVMASK) begin
      rdata_next = {6'h00, evmask_reg};
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rdata_next;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_start_clear: assert property (@(posedge clk) disable iff (srst)
    start_reg && conv_started && !wr_ctrl |=> !start_reg) else $error("start bit not cleared");
  a_start_set: assert property (@(posedge clk) disable iff (srst)
    wr_ctrl && reg_wdata[`ADCCFG_CTRL_START] |=> start_reg) else $error("start bit not set");
  a_start_hold: assert property (@(posedge clk) disable iff (srst)
    start_reg && !conv_started |=> start_reg) else $error("start bit dropped early");
  a_flag_sets: assert property (@(posedge clk) disable iff (srst)
    conv_done && irq_condition_select == ADCCFG_IRQ_COMPLETE && !wr_irqctl ##1 1'b1 |=> flag_reg)
    else $error("flag missed completion");
  a_flag_w1c: assert property (@(posedge clk) disable iff (srst)
    wr_flags && reg_wdata[`ADCCFG_FLAG_BIT] && !flag_set |=> !flag_reg) else $error("flag not cleared");
  a_flag_vector: assert property (@(posedge clk) disable iff (srst)
    irq_vector_ack && !flag_set |=> !flag_reg) else $error("flag kept after vector");
  a_rsvd_cond: assert property (@(posedge clk) disable iff (srst)
    done_q && irq_condition_select == ADCCFG_IRQ_RESERVED && !flag_reg |=> !flag_reg)
    else $error("reserved condition set flag");
  a_irq_enable: assert property (@(posedge clk) disable iff (srst)
    wr_irqctl && reg_wdata[`ADCCFG_IRQ_LVL_HI:`ADCCFG_IRQ_LVL_LO] == 2'h0 |=> !irq_request)
    else $error("request while disabled");
  a_irq_raise: assert property (@(posedge clk) disable iff (srst)
    flag_set && level_reg != 2'h0 && !wr_irqctl |=> irq_request) else $error("request missing");
  a_gain_only: assert property (@(posedge clk) disable iff (srst)
    gain_enable |-> signed_conversion_select && channel_input_kind == ADCCFG_IN_DIFF_GAIN)
    else $error("gain outside gain mode");
  a_unsigned_rsvd: assert property (@(posedge clk) disable iff (srst)
    !signed_conversion_select && channel_input_kind[1] |-> input_reserved && neg_kind == ADCCFG_NEG_NONE)
    else $error("reserved kind not flagged");
  a_internal_rsvd: assert property (@(posedge clk) disable iff (srst)
    channel_input_kind == ADCCFG_IN_INTERNAL && positive_input_select > 4'h2 |-> input_reserved)
    else $error("reserved source not flagged");
  a_neg_ignored: assert property (@(posedge clk) disable iff (srst)
    !channel_input_kind[1] |-> neg_kind == ADCCFG_NEG_NONE) else $error("negative select used");
  a_neg_gain_pin: assert property (@(posedge clk) disable iff (srst)
    diff_with_amplification && neg_kind == ADCCFG_NEG_PIN |-> neg_pin[2]) else $error("gain pin wrong");
  a_pos_pin: assert property (@(posedge clk) disable iff (srst)
    channel_input_kind == ADCCFG_IN_SINGLE |-> pos_kind == ADCCFG_POS_PIN && pos_pin == positive_input_select)
    else $error("positive pin wrong");
  a_rsvd_zero: assert property (@(posedge clk) disable iff (srst)
    $past(reg_rd) && $past(reg_addr) == `ADCCFG_OFS_MUX |-> !reg_rdata[7]) else $error("reserved bit read");

endmodule : adccfg_channel

// file: adccfg_pkg.sv
// Types of the ADC channel configuration block
package adccfg_pkg;
  typedef enum logic [1:0] {
    ADCCFG_IN_INTERNAL = 2'b00,
    ADCCFG_IN_SINGLE = 2'b01,
    ADCCFG_IN_DIFF = 2'b10,
    ADCCFG_IN_DIFF_GAIN = 2'b11
  } adccfg_input_kind_t;
  typedef enum logic [1:0] {
    ADCCFG_IRQ_COMPLETE = 2'b00,
    ADCCFG_IRQ_BELOW = 2'b01,
    ADCCFG_IRQ_RESERVED = 2'b10,
    ADCCFG_IRQ_ABOVE = 2'b11
  } adccfg_irq_cond_t;
  typedef enum logic [3:0] {
    ADCCFG_NEG_NONE = 4'h0,
    ADCCFG_NEG_PIN = 4'h1,
    ADCCFG_NEG_PAD_GND = 4'h2,
    ADCCFG_NEG_INT_GND = 4'h3
  } adccfg_neg_kind_t;
  typedef enum logic [2:0] {
    ADCCFG_POS_NONE = 3'h0,
    ADCCFG_POS_TEMP = 3'h1,
    ADCCFG_POS_BANDGAP = 3'h2,
    ADCCFG_POS_SUPPLY_TENTH = 3'h3,
    ADCCFG_POS_PIN = 3'h4
  } adccfg_pos_kind_t;
endpackage : adccfg_pkg

// file: test_adc_channel_config.sv
// Self-checking testbench of the ADC channel configuration block
`timescale 1ns/10ps
`include "adccfg_cfg.svh"
module test_adc_channel_config
  import adccfg_pkg::*;
;
  logic clk;
  logic srst;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  logic signed_conversion_select;
  logic conv_start;
  logic conv_started;
  logic conv_done;
  logic [11:0] conv_result;
  logic [2:0] gain_select;
  logic gain_enable;
  adccfg_pos_kind_t pos_kind;
  logic [3:0] pos_pin;
  adccfg_neg_kind_t neg_kind;
  logic [2:0] neg_pin;
  logic input_reserved;
  logic irq_request;
  logic [1:0] irq_priority_level;
  logic irq_vector_ack;
  logic irq;
  int err_count = 0;
  int checks = 0;
  int cycles = 0;
  logic [7:0] rv;
  // Negative select decode per differential kind, 4'hf marks a reserved code
  logic [3:0] nk_plain [8] = '{4'h1, 4'h1, 4'h1, 4'h1, 4'hf, 4'h2, 4'hf, 4'h3};
  logic [3:0] nk_gain [8] = '{4'h1, 4'h1, 4'h1, 4'h1, 4'h3, 4'hf, 4'hf, 4'h2};
  // Compare cases: condition, result, expected request
  logic [1:0] cc [8] = '{2'h1, 2'h1, 2'h1, 2'h3, 2'h3, 2'h3, 2'h2, 2'h2};
  logic [11:0] cr [8] = '{12'h080, 12'h200, 12'h100, 12'h200, 12'h080, 12'h100, 12'h200, 12'h080};
  logic ce [8] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};

  adccfg_channel #(.RES_W(12)) uut (
    .clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .signed_conversion_select(signed_conversion_select),
    .conv_start(conv_start), .conv_started(conv_started), .conv_done(conv_done),
    .conv_result(conv_result), .gain_select(gain_select), .gain_enable(gain_enable),
    .pos_kind(pos_kind), .pos_pin(pos_pin), .neg_kind(neg_kind), .neg_pin(neg_pin),
    .input_reserved(input_reserved), .irq_request(irq_request),
    .irq_priority_level(irq_priority_level), .irq_vector_ack(irq_vector_ack), .irq(irq)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ----------------------------------------
  // Common tasks
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks = checks + 1;
    if (got !== exp) begin
      err_count = err_count + 1;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : results

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd

  task automatic sgn(input logic v);
    @(posedge clk);
    signed_conversion_select <= v;
    #1;
  endtask : sgn

  task automatic done(input logic [11:0] res);
    @(posedge clk);
    conv_done <= 1'b1;
    conv_result <= res;
    @(posedge clk);
    conv_done <= 1'b0;
    conv_result <= ~res;
    @(posedge clk);
    #1;
  endtask : done

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    logic [7:0] al [8] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h08, 8'h09, 8'h0a, 8'hff};
    for (int i = 0; i < 8; i++) begin
      rd(al[i], rv);
      chk(rv, 8'h00);
    end
    chk(conv_start, 1'b0);
    chk(irq, 1'b0);
  endtask : t_reset

  task automatic t_gain();
    sgn(1'b1);
    for (int g = 0; g < 8; g++) begin
      wr(8'h00, {3'h0, 3'(g), 2'b11});
      chk(gain_select, 16'(g));
      chk(gain_enable, 1'b1);
    end
    wr(8'h00, 8'h1e);
    chk(gain_enable, 1'b0);
    chk(input_reserved, 1'b0);
    rd(8'h00, rv);
    chk(rv, 8'h1e);
    sgn(1'b0);
    chk(input_reserved, 1'b1);
    wr(8'h00, 8'h03);
    chk(input_reserved, 1'b1);
    chk(gain_enable, 1'b0);
  endtask : t_gain

  task automatic t_mux();
    wr(8'h00, 8'h00);
    for (int p = 0; p < 16; p++) begin
      wr(8'h01, {1'b0, 4'(p), 3'b011});
      chk(input_reserved, 16'(p > 2));
      if (p < 3) chk(pos_kind, 16'(p + 1));
      chk(neg_kind, ADCCFG_NEG_NONE);
    end
    wr(8'h00, 8'h01);
    for (int p = 0; p < 16; p++) begin
      wr(8'h01, {1'b0, 4'(p), 3'b001});
      chk({pos_kind, pos_pin}, {ADCCFG_POS_PIN, 4'(p)});
      chk(neg_kind, ADCCFG_NEG_NONE);
    end
    sgn(1'b1);
    for (int m = 2; m < 4; m++) begin
      wr(8'h00, 8'(m));
      for (int n = 0; n < 8; n++) begin
        wr(8'h01, {1'b0, 4'hc, 3'(n)});
        chk({pos_kind, pos_pin}, {ADCCFG_POS_PIN, 4'hc});
        if (m == 2 && nk_plain[n] != 4'hf) chk(neg_kind, nk_plain[n]);
        if (m == 3 && nk_gain[n] != 4'hf) chk(neg_kind, nk_gain[n]);
        if (n < 4) chk(neg_pin, 16'(n + (m - 2) * 4));
      end
    end
    wr(8'h01, 8'h7f);
    rd(8'h01, rv);
    chk(rv, 8'h7f);
  endtask : t_mux

  task automatic t_irq();
    sgn(1'b0);
    wr(8'h00, 8'h01);
    wr(8'h02, 8'h02);
    rd(8'h02, rv);
    chk(rv, 8'h02);
    done(12'h123);
    chk({irq_request, irq_priority_level}, 3'b110);
    rd(8'h03, rv);
    chk(rv, 8'h01);
    wr(8'h03, 8'h01);
    chk(irq_request, 1'b0);
    done(12'h456);
    @(posedge clk);
    irq_vector_ack <= 1'b1;
    @(posedge clk);
    irq_vector_ack <= 1'b0;
    @(posedge clk);
    #1;
    chk(irq_request, 1'b0);
    wr(8'h02, 8'h00);
    done(12'h789);
    chk(irq_request, 1'b0);
    rd(8'h03, rv);
    chk(rv, 8'h01);
    wr(8'h04, 8'h00);
    wr(8'h05, 8'h01);
    for (int i = 0; i < 8; i++) begin
      wr(8'h03, 8'h01);
      wr(8'h02, {4'h0, cc[i], 2'b01});
      done(cr[i]);
      chk(irq_request, ce[i]);
    end
    sgn(1'b1);
    wr(8'h02, 8'h05);
    done(12'hf00);
    chk(irq_request, 1'b1);
    rd(8'h07, rv);
    chk(rv, 8'hff);
    rd(8'h06, rv);
    chk(rv, 8'h00);
    rd(8'h05, rv);
    chk(rv, 8'h01);
    wr(8'h03, 8'h01);
  endtask : t_irq

  task automatic t_start();
    wr(8'h02, 8'h00);
    rd(8'h08, rv);
    wr(8'h00, 8'h81);
    chk(conv_start, 1'b1);
    wr(8'h00, 8'h81);
    wr(8'h00, 8'h01);
    chk(conv_start, 1'b1);
    wr(8'h09, 8'h02);
    @(posedge clk);
    conv_started <= 1'b1;
    @(posedge clk);
    conv_started <= 1'b0;
    @(posedge clk);
    #1;
    chk({conv_start, irq}, 2'b01);
    rd(8'h08, rv);
    chk({rv, irq}, {8'h02, 1'b0});
    wr(8'h09, 8'h00);
    done(12'h001);
    chk(irq, 1'b0);
    wr(8'h09, 8'h01);
    chk(irq, 1'b1);
    rd(8'h08, rv);
    chk({rv, irq}, {8'h01, 1'b0});
  endtask : t_start

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count = err_count + 1;
      results();
    end
  end

  initial begin
    srst = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    signed_conversion_select = 1'b0;
    conv_started = 1'b0;
    conv_done = 1'b0;
    conv_result = 12'h000;
    irq_vector_ack = 1'b0;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    t_gain();
    t_mux();
    t_irq();
    t_start();
    results();
  end
endmodule : test_adc_channel_config
